// File: test/ctbr_checker.sv
// assertion checker for the charger control register bank
`timescale 1ns/1ps
`default_nettype none
module ctbr_checker (
   input wire logic                   CLK,
   input wire logic                   SYS_RST,
   input wire logic                   SOFT_RESET,
   input wire ctbr_pkg::ctbr_req_type REQ,
   input wire logic                   OPT_DONE,
   input wire logic                   PULSE_FEATURE_ENABLE,
   input wire logic                   PULSE_DONE,
   input wire logic                   FAULT_READ,
   input wire logic                   OPT_START,
   input wire logic                   PULSE_RAISE,
   input wire logic                   PULSE_LOWER,
   input wire logic                   BATTERY_SWITCH_ON,
   input wire logic                   SAFETY_TIMER_ENABLE,
   input wire logic                   WATCHDOG_FAULT,
   input wire logic [1:0]             CHARGE_FAULT_CODE,
   input wire ctbr_pkg::ctbr_cfg_type CFG
);
   logic w7, w8, w9; // host writes per register, soft reset excluded
   assign w7 = REQ.wr && REQ.addr == 8'h07 && !SOFT_RESET;
   assign w8 = REQ.wr && REQ.addr == 8'h08 && !SOFT_RESET;
   assign w9 = REQ.wr && REQ.addr == 8'h09 && !SOFT_RESET;
   default clocking @(posedge CLK); endclocking
   default disable iff (SYS_RST);
   ////////////////////////////////////////////////////////////////////////////
   // field decode follows the written value one cycle later
   chk_term_pin_bits: assert property (w7 |=> CFG.term_enable ==
      $past(REQ.wdata[7]) && CFG.indicator_pin_disable == $past(REQ.wdata[6]))
      else $error("termination or pin bit wrong");
   chk_timer_enable: assert property (w7 |=>
      SAFETY_TIMER_ENABLE == $past(REQ.wdata[3])) else $error("timer enable");
   chk_comp_weights: assert property (w8 |=>
      CFG.compensation_resistance == 8'h14 * $past(REQ.wdata[7:5]) &&
      CFG.compensation_clamp == 8'h20 * $past(REQ.wdata[4:2]))
      else $error("compensation decode wrong");
   chk_thermal_code: assert property (w8 |=>
      CFG.thermal_regulation_threshold == 8'h3c + 8'h14 * $past(REQ.wdata[1:0]))
      else $error("thermal threshold wrong");
   // set-only bit survives a zero write until the optimiser finishes
   chk_opt_set_only: assert property (OPT_START && !OPT_DONE && w9
      |=> OPT_START) else $error("optimiser bit cleared by host");
   chk_pulse_gate: assert property (w9 && !PULSE_FEATURE_ENABLE &&
      !PULSE_RAISE && !PULSE_LOWER |=> !PULSE_RAISE && !PULSE_LOWER)
      else $error("pulse bit set while feature off");
   chk_pulse_clear: assert property (PULSE_DONE &&
      !(REQ.wr && REQ.addr == 8'h09) |=> !PULSE_RAISE && !PULSE_LOWER)
      else $error("pulse bits not cleared");
   // ship mode: immediate path is two cycles, delayed path holds much longer
   chk_ship_now: assert property (disable iff (SYS_RST || SOFT_RESET)
      w9 && REQ.wdata[5] && !REQ.wdata[3] |-> ##2 !BATTERY_SWITCH_ON)
      else $error("switch not off after two cycles");
   chk_ship_wait: assert property (w9 && REQ.wdata[5] && REQ.wdata[3] &&
      BATTERY_SWITCH_ON |=> BATTERY_SWITCH_ON [*8])
      else $error("switch off before delay");
   chk_wdog_sticky: assert property (WATCHDOG_FAULT && !FAULT_READ &&
      !SOFT_RESET |=> WATCHDOG_FAULT) else $error("watchdog fault dropped");
   cover property (!BATTERY_SWITCH_ON);
   cover property ($rose(WATCHDOG_FAULT));
   cover property (CHARGE_FAULT_CODE == 2'h3);
endmodule
bind ctbr_regs ctbr_checker u_ctbr_checker (.CLK(CLK), .SYS_RST(SYS_RST),
   .SOFT_RESET(SOFT_RESET), .REQ(REQ), .OPT_DONE(OPT_DONE),
   .PULSE_FEATURE_ENABLE(PULSE_FEATURE_ENABLE), .PULSE_DONE(PULSE_DONE),
   .FAULT_READ(FAULT_READ), .OPT_START(OPT_START), .PULSE_RAISE(PULSE_RAISE),
   .PULSE_LOWER(PULSE_LOWER), .BATTERY_SWITCH_ON(BATTERY_SWITCH_ON),
   .SAFETY_TIMER_ENABLE(SAFETY_TIMER_ENABLE), .WATCHDOG_FAULT(WATCHDOG_FAULT),
   .CHARGE_FAULT_CODE(CHARGE_FAULT_CODE), .CFG(CFG));
`default_nettype wire

// File: test/ctbr_host.sv
// host model issuing one-cycle register requests to the bank
`timescale 1ns/1ps
`default_nettype none
module ctbr_host (
   input  wire logic             clk,
   input  wire logic [7:0]       rdata,
   output var ctbr_pkg::ctbr_req_type req
);
   // idle bus carries no strobe
   initial req = '0;
   // write: strobe held for exactly one taking edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      #1 req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk);
      // stale data never looks valid
      #1 req = '{wr: 1'b0, rd: 1'b0, addr: a, wdata: ~d};
   endtask
   // read: data is registered at the taking edge
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      #1 req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge clk);
      #1 req.rd = 1'b0;
      d = rdata;
   endtask
endmodule
`default_nettype wire

// File: test/ctbr_regs_tb.sv
// self-checking testbench for the charger control register bank
`timescale 1ns/1ps
`default_nettype none
module ctbr_regs_tb;
   localparam longint SEC = 2;   // shortened second keeps the run short
   localparam longint SDLY = 20; // shortened ship-mode delay
   logic clk, sys_rst, soft_rst, chg, reg_act, opt_done, pf_en, p_done, f_rd;
   logic opt_st, p_up, p_dn, sw_on, t_en, wd_f;
   logic [1:0] cf;
   logic [7:0] rdata;
   ctbr_pkg::ctbr_req_type req;
   ctbr_pkg::ctbr_cfg_type cfg;
   int fail_count = 0;
   int check_count = 0;
   // 125 MHz clock
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   ctbr_regs #(.SEC_CYCLES(SEC), .SHIP_DLY_CYCLES(SDLY)) u_ctbr_regs (
      .CLK(clk), .SYS_RST(sys_rst), .SOFT_RESET(soft_rst), .REQ(req),
      .RDATA(rdata), .CHARGING(chg), .REGULATING(reg_act),
      .OPT_DONE(opt_done), .PULSE_FEATURE_ENABLE(pf_en),
      .PULSE_DONE(p_done), .FAULT_READ(f_rd), .OPT_START(opt_st),
      .PULSE_RAISE(p_up), .PULSE_LOWER(p_dn), .BATTERY_SWITCH_ON(sw_on),
      .SAFETY_TIMER_ENABLE(t_en), .WATCHDOG_FAULT(wd_f),
      .CHARGE_FAULT_CODE(cf), .CFG(cfg));
   ctbr_host u_ctbr_host (.clk(clk), .rdata(rdata), .req(req));
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string n, input logic [31:0] e, g);
      check_count++;
      if (e !== g) begin
         fail_count++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic rchk(input logic [7:0] a, e);
      logic [7:0] v;
      u_ctbr_host.rd(a, v);
      chk("rdata", e, v);
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // one-cycle pulse, entered just after an edge
   task automatic pulse(ref logic s);
      s = 1'b1;
      step(1);
      s = 1'b0;
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_defaults;
      rchk(8'h07, 8'h9d);
      rchk(8'h08, 8'h03);
      rchk(8'h09, 8'h44);
      rchk(8'h0a, 8'h00); // unmapped reads as zero
      chk("switch", 1, sw_on);
      chk("thr", 8'h78, cfg.thermal_regulation_threshold);
      chk("slow", 1, cfg.timer_slowdown_enable);
      chk("srst", 1, cfg.system_reset_enable);
   endtask
   // field decode; 0x42 also switches the watchdog off
   task automatic t_fields;
      u_ctbr_host.wr(8'h07, 8'h42);
      chk("term", 0, cfg.term_enable);
      chk("ind", 1, cfg.indicator_pin_disable);
      chk("tmr_en", 0, t_en);
      for (int i = 0; i < 4; i++) begin
         u_ctbr_host.wr(8'h08, {6'h3f, 2'(i)});
         chk("thr", 60 + 20 * i, cfg.thermal_regulation_threshold);
      end
      chk("res", 140, cfg.compensation_resistance);
      chk("clamp", 224, cfg.compensation_clamp);
      u_ctbr_host.wr(8'h08, 8'h54);
      chk("res", 40, cfg.compensation_resistance);
      chk("clamp", 160, cfg.compensation_clamp);
      u_ctbr_host.wr(8'h0b, 8'h00);
      rchk(8'h08, 8'h54);
   endtask
   task automatic t_opt_pulse;
      u_ctbr_host.wr(8'h09, 8'hc4);
      chk("opt", 1, opt_st);
      u_ctbr_host.wr(8'h09, 8'h44);
      chk("opt", 1, opt_st);
      pulse(opt_done);
      chk("opt", 0, opt_st);
      u_ctbr_host.wr(8'h09, 8'h47);
      chk("pulse", 0, {p_up, p_dn});
      pf_en = 1'b1;
      u_ctbr_host.wr(8'h09, 8'h46);
      chk("pulse", 2, {p_up, p_dn});
      u_ctbr_host.wr(8'h09, 8'h47);
      chk("pulse", 3, {p_up, p_dn});
      pulse(p_done);
      chk("pulse", 0, {p_up, p_dn});
      pf_en = 1'b0;
   endtask
   task automatic t_ship;
      u_ctbr_host.wr(8'h09, 8'h20);
      chk("srst", 0, cfg.system_reset_enable);
      step(3);
      chk("switch", 0, sw_on);
      pulse(soft_rst);
      chk("switch", 1, sw_on);
      rchk(8'h09, 8'h44);
      u_ctbr_host.wr(8'h09, 8'h2c);
      step(SDLY - 4);
      chk("switch", 1, sw_on);
      step(8);
      chk("switch", 0, sw_on);
      pulse(soft_rst);
   endtask
   // each period code, then the disabled code
   task automatic t_wdog;
      int n;
      int e;
      u_ctbr_host.wr(8'h09, 8'h18);
      for (int k = 1; k < 4; k++) begin
         u_ctbr_host.wr(8'h08, 8'hff);
         u_ctbr_host.wr(8'h07, {2'h0, 2'(k), 4'h0});
         e = int'(40 * SEC) << (k - 1);
         n = 0;
         while (wd_f !== 1'b1 && n < 400) begin
            step(1);
            n++;
         end
         chk("wdog_span", 1, n > e - 5 && n < e + 3);
         rchk(8'h07, 8'h9d);
         rchk(8'h08, 8'h03);
         rchk(8'h09, 8'h58);
         pulse(f_rd);
         chk("wdog_flt", 0, wd_f);
      end
      u_ctbr_host.wr(8'h07, 8'h00);
      step(400);
      chk("wdog_flt", 0, wd_f);
   endtask
   // five-hour limit, halved speed while regulating
   task automatic t_safety;
      int n;
      u_ctbr_host.wr(8'h07, 8'h08);
      chg = 1'b1;
      reg_act = 1'b1;
      n = 0;
      while (cf === 2'h0 && n < 80000) begin
         step(1);
         n++;
      end
      chk("safe_span", 1, n > 71990 && n < 72010);
      chk("fault", 3, cf);
      chg = 1'b0;
      reg_act = 1'b0;
   endtask
   // hang guard, well beyond the longest wait
   initial begin
      #(8 * 90000);
      fail_count++;
      summarize();
   end
   initial begin
      {sys_rst, soft_rst, chg, reg_act} = 4'h8;
      {opt_done, pf_en, p_done, f_rd} = 4'h0;
      step(5);
      sys_rst = 1'b0;
      t_defaults();
      t_fields();
      t_opt_pulse();
      t_ship();
      t_wdog();
      t_safety();
      summarize();
   end
endmodule
`default_nettype wire

// File: verilog/ctbr_pkg.sv
// package: offsets, field layouts, reset values and timing for the control bank
`default_nettype none
package ctbr_pkg;
   // register offsets on the register port
   localparam logic [7:0] OFS_TERM_TIMER = 8'h07;
   localparam logic [7:0] OFS_COMP_THERM = 8'h08;
   localparam logic [7:0] OFS_OPT_BATSW  = 8'h09;
   // reset values
   localparam logic [7:0] RST_TERM_TIMER = 8'h9d;
   localparam logic [7:0] RST_COMP_THERM = 8'h03;
   localparam logic [7:0] RST_OPT_BATSW  = 8'h44;
   // field positions, first control register
   localparam int TERM_EN_BIT  = 7;
   localparam int IND_DIS_BIT  = 6;
   localparam int WDOG_LSB     = 4;
   localparam int TMR_EN_BIT   = 3;
   localparam int DUR_LSB      = 1;
   // field positions, second control register
   localparam int CRES_LSB     = 5;
   localparam int CCLAMP_LSB   = 2;
   localparam int THERMAL_REGULATION_THRESHOLD_LSB     = 0;
   // field positions, third control register
   localparam int FOPT_BIT     = 7;
   localparam int SLOW_BIT     = 6;
   localparam int BSW_DIS_BIT  = 5;
   localparam int BSW_DLY_BIT  = 3;
   localparam int SRST_EN_BIT  = 2;
   localparam int RAISE_BIT    = 1;
   localparam int LOWER_BIT    = 0;
   // bits of the third register kept through a watchdog expiry
   localparam logic [7:0] WDOG_KEEP_MASK = 8'h3c;
   // fault code for safety timer expiry
   localparam logic [1:0] FAULT_SAFETY_TMR = 2'h3;
   // timing: clock rate and second tick
   localparam longint CLK_HZ        = 125000000;
   localparam longint SEC_CYCLES    = CLK_HZ;
   localparam int     WDOG_40_S     = 40;
   localparam int     WDOG_80_S     = 80;
   localparam int     WDOG_160_S    = 160;
   localparam int     DUR_5_H       = 5;
   localparam int     DUR_8_H       = 8;
   localparam int     DUR_12_H      = 12;
   localparam int     DUR_20_H      = 20;
   localparam int     SEC_PER_HOUR  = 3600;
   // thermal thresholds in degrees C
   localparam logic [7:0] THERMAL_REGULATION_THRESHOLD_60  = 8'h3c;
   localparam logic [7:0] THERMAL_REGULATION_THRESHOLD_80  = 8'h50;
   localparam logic [7:0] THERMAL_REGULATION_THRESHOLD_100 = 8'h64;
   localparam logic [7:0] THERMAL_REGULATION_THRESHOLD_120 = 8'h78;
   // compensation weights: resistance per lsb in mohm, clamp in mV
   localparam logic [7:0] CRES_STEP_MOHM = 8'h14;
   localparam logic [7:0] CCLAMP_STEP_MV = 8'h20;
   // register port write/read request carried as one bundle
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } ctbr_req_type;
   // decoded settings handed to the charger logic
   typedef struct packed {
      logic       term_enable;
      logic       indicator_pin_disable;
      logic       timer_slowdown_enable;
      logic       system_reset_enable;
      logic [7:0] thermal_regulation_threshold;
      logic [7:0] compensation_resistance;
      logic [7:0] compensation_clamp;
   } ctbr_cfg_type;
endpackage
`default_nettype wire

// File: verilog/ctbr_regs.sv
// charger control register bank: termination, timers, compensation, switch
`timescale 1ns/1ps
`default_nettype none
module ctbr_regs #(
   parameter longint SEC_CYCLES      = ctbr_pkg::SEC_CYCLES,
   parameter longint SHIP_DLY_CYCLES = 64'd1250000000
) (
   input  wire logic                    CLK,
   input  wire logic                    SYS_RST,
   input  wire logic                    SOFT_RESET,
   input  wire ctbr_pkg::ctbr_req_type  REQ,
   output logic [7:0]                   RDATA,
   input  wire logic                    CHARGING,
   input  wire logic                    REGULATING,
   input  wire logic                    OPT_DONE,
   input  wire logic                    PULSE_FEATURE_ENABLE,
   input  wire logic                    PULSE_DONE,
   input  wire logic                    FAULT_READ,
   output logic                         OPT_START,
   output logic                         PULSE_RAISE,
   output logic                         PULSE_LOWER,
   output logic                         BATTERY_SWITCH_ON,
   output logic                         SAFETY_TIMER_ENABLE,
   output logic                         WATCHDOG_FAULT,
   output logic [1:0]                   CHARGE_FAULT_CODE,
   output ctbr_pkg::ctbr_cfg_type       CFG
);
   ////////////////////////////////////////////////////////////////////////
   // registers and decode
   // three byte registers at 0x07 to 0x09
   // host-visible register state
   logic [7:0]  term_timer_r;   // first control register
   logic [7:0]  comp_therm_r;   // second control register
   logic [7:0]  opt_batsw_r;    // third control register
   logic [7:0]  opt_batsw_nxt;  // third register next value
   // event pulses and decode
   logic        wdog_exp;       // watchdog expiry pulse
   logic        safety_exp;     // safety timer expiry pulse
   logic        host_access;    // any register access kicks watchdog
   logic        wr07;           // write to first register
   logic        wr08;           // write to second register
   logic        wr09;           // write to third register
   // timing state; sec_cnt_r and half_r cleared by SYS_RST only, the rest by either reset
   logic [35:0] sec_cnt_r;      // prescaler to one second
   logic        sec_tick;       // one-second strobe
   logic        half_r;         // toggles to halve safety rate
   logic        safety_tick;    // safety timer advance
   logic [35:0] dly_cnt_r;      // ship mode delay counter
   logic        switch_off_r;   // battery switch forced off
   // limits in seconds, zero means off
   logic [17:0] wdog_limit;     // watchdog period in seconds
   logic [17:0] safety_limit;   // safety limit in seconds

   // one-cycle strobes, so each write lands once
   // reads also count as host activity
   assign host_access = REQ.wr | REQ.rd;
   assign wr07 = REQ.wr && REQ.addr == ctbr_pkg::OFS_TERM_TIMER;
   assign wr08 = REQ.wr && REQ.addr == ctbr_pkg::OFS_COMP_THERM;
   assign wr09 = REQ.wr && REQ.addr == ctbr_pkg::OFS_OPT_BATSW;

   // two-bit field to period in seconds
   // code zero gives limit zero: timer disabled
   function automatic logic [17:0] wdog_secs(input logic [1:0] f);
      case (f)
         2'h0:    wdog_secs = 18'h0; // watchdog off
         2'h1:    wdog_secs = 18'(ctbr_pkg::WDOG_40_S);
         2'h2:    wdog_secs = 18'(ctbr_pkg::WDOG_80_S);
         default: wdog_secs = 18'(ctbr_pkg::WDOG_160_S);
      endcase
   endfunction

   // two-bit field to hours limit in seconds
   // 20 h is 72000 s, inside the 18-bit limit
   function automatic logic [17:0] dur_secs(input logic [1:0] f);
      case (f)
         2'h0:    dur_secs = 18'(ctbr_pkg::DUR_5_H * ctbr_pkg::SEC_PER_HOUR);
         2'h1:    dur_secs = 18'(ctbr_pkg::DUR_8_H * ctbr_pkg::SEC_PER_HOUR);
         2'h2:    dur_secs = 18'(ctbr_pkg::DUR_12_H * ctbr_pkg::SEC_PER_HOUR);
         default: dur_secs = 18'(ctbr_pkg::DUR_20_H * ctbr_pkg::SEC_PER_HOUR);
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // time base
   // free-running second strobe, shared by both timers
   // one shared prescaler: a restarted timer may
   // lose up to a second of its first period
   // SEC_CYCLES lets a bench shorten the second
   always_ff @(posedge CLK) begin
      if (SYS_RST || sec_cnt_r == 36'(SEC_CYCLES - 1)) begin
         sec_cnt_r <= 36'h0;
      end else begin
         sec_cnt_r <= sec_cnt_r + 36'h1;
      end
   end
   // strobe high in the last prescaler cycle
   assign sec_tick = sec_cnt_r == 36'(SEC_CYCLES - 1);

   // halve the safety rate while regulating if slowdown enabled
   // half_r flips each second; gating passes every
   // other tick, phase set by the free prescaler
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         half_r <= 1'b0;
      end else if (sec_tick) begin
         half_r <= ~half_r;
      end
   end
   // otherwise every second counts
   assign safety_tick = sec_tick &&
      (!(REGULATING && opt_batsw_r[ctbr_pkg::SLOW_BIT]) || half_r);

   ////////////////////////////////////////////////////////////////////////
   // timers
   // both count whole seconds from sec_tick
   // watchdog restarts on every host access; field zero disables it
   // clear wins over counting; expiry is one pulse
   // soft reset restarts it as well
   ctbr_sec_timer u_wdog (
      .clk     (CLK),
      .rst     (SYS_RST || SOFT_RESET),
      .clear   (host_access),
      .run     (1'b1),
      .tick    (sec_tick),
      .limit   (wdog_limit),
      .expired (wdog_exp)
   );
   assign wdog_limit =
      wdog_secs(term_timer_r[ctbr_pkg::WDOG_LSB +: 2]);

   // safety timer runs only while charging with the timer enabled
   // losing charge or enable restarts the limit;
   // a partly used period is not resumed
   ctbr_sec_timer u_safety (
      .clk     (CLK),
      .rst     (SYS_RST || SOFT_RESET),
      .clear   (1'b0),
      .run     (CHARGING && term_timer_r[ctbr_pkg::TMR_EN_BIT]),
      .tick    (safety_tick),
      .limit   (safety_limit),
      .expired (safety_exp)
   );
   assign safety_limit =
      dur_secs(term_timer_r[ctbr_pkg::DUR_LSB +: 2]);

   ////////////////////////////////////////////////////////////////////////
   // first and second control registers
   // both fully restored by soft reset or watchdog expiry
   // restores win over a same-cycle host write
   // reserved bit0 is plain storage
   always_ff @(posedge CLK) begin
      if (SYS_RST || SOFT_RESET || wdog_exp) begin
         term_timer_r <= ctbr_pkg::RST_TERM_TIMER;
      end else if (wr07) begin
         term_timer_r <= REQ.wdata;
      end
   end

   // second register: compensation, threshold
   always_ff @(posedge CLK) begin
      if (SYS_RST || SOFT_RESET || wdog_exp) begin
         comp_therm_r <= ctbr_pkg::RST_COMP_THERM;
      end else if (wr08) begin
         comp_therm_r <= REQ.wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // third control register: set-only and self-clearing bits
   // priority by order: host write, completions,
   // then the watchdog restore last
   always_comb begin
      opt_batsw_nxt = opt_batsw_r;
      // host write replaces the whole byte first
      if (wr09) begin
         opt_batsw_nxt = REQ.wdata;
         // host may only set the optimiser start
         opt_batsw_nxt[ctbr_pkg::FOPT_BIT] =
            opt_batsw_r[ctbr_pkg::FOPT_BIT] |
            REQ.wdata[ctbr_pkg::FOPT_BIT];
         // pulse requests accept a one only with feature enabled
         // feature off: a write may clear, never set
         if (!PULSE_FEATURE_ENABLE) begin
            opt_batsw_nxt[ctbr_pkg::RAISE_BIT] =
               opt_batsw_r[ctbr_pkg::RAISE_BIT] &
               REQ.wdata[ctbr_pkg::RAISE_BIT];
            opt_batsw_nxt[ctbr_pkg::LOWER_BIT] =
               opt_batsw_r[ctbr_pkg::LOWER_BIT] &
               REQ.wdata[ctbr_pkg::LOWER_BIT];
         end
      end
      // completion clears only if no new set arrives the same cycle
      if (OPT_DONE && !(wr09 && REQ.wdata[ctbr_pkg::FOPT_BIT])) begin
         opt_batsw_nxt[ctbr_pkg::FOPT_BIT] = 1'b0;
      end
      // same for the pulse pair
      if (PULSE_DONE && !(wr09 && PULSE_FEATURE_ENABLE &&
          (REQ.wdata[ctbr_pkg::RAISE_BIT] ||
           REQ.wdata[ctbr_pkg::LOWER_BIT]))) begin
         opt_batsw_nxt[ctbr_pkg::RAISE_BIT] = 1'b0;
         opt_batsw_nxt[ctbr_pkg::LOWER_BIT] = 1'b0;
      end
      // watchdog restores all but the switch bits, the reset enable bit and the reserved bit
      if (wdog_exp) begin
         opt_batsw_nxt = (opt_batsw_r & ctbr_pkg::WDOG_KEEP_MASK) |
            (ctbr_pkg::RST_OPT_BATSW & ~ctbr_pkg::WDOG_KEEP_MASK);
      end
   end

   // only soft reset or SYS_RST restores the battery switch bits
   // watchdog restore is already in the next value
   always_ff @(posedge CLK) begin
      if (SYS_RST || SOFT_RESET) begin
         opt_batsw_r <= ctbr_pkg::RST_OPT_BATSW;
      end else begin
         opt_batsw_r <= opt_batsw_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // battery switch control
   // ship mode: switch off, now or delayed
   // delay counter runs from the disable write, whether or not delay is chosen
   // saturates so the off decision stays stable;
   // SHIP_DLY_CYCLES defaults to 10 s at 125 MHz
   always_ff @(posedge CLK) begin
      if (SYS_RST || SOFT_RESET || !opt_batsw_r[ctbr_pkg::BSW_DIS_BIT]) begin
         dly_cnt_r <= 36'h0;
      end else if (dly_cnt_r != 36'(SHIP_DLY_CYCLES)) begin
         dly_cnt_r <= dly_cnt_r + 36'h1;
      end
   end

   // switch goes off at once, or after the ship mode delay
   // stays off while the disable bit is held;
   // only a zero write, soft reset or SYS_RST frees it
   always_ff @(posedge CLK) begin
      if (SYS_RST || SOFT_RESET) begin
         switch_off_r <= 1'b0;
      end else if (!opt_batsw_r[ctbr_pkg::BSW_DIS_BIT]) begin
         switch_off_r <= 1'b0;
      end else if (!opt_batsw_r[ctbr_pkg::BSW_DLY_BIT] ||
                   dly_cnt_r == 36'(SHIP_DLY_CYCLES)) begin
         switch_off_r <= 1'b1;
      end
   end
   // high means the switch may conduct
   assign BATTERY_SWITCH_ON = ~switch_off_r;

   ////////////////////////////////////////////////////////////////////////
   // fault status
   // faults are sticky until FAULT_READ
   // watchdog fault held until the host reads the fault register
   // expiry wins over a same-cycle read
   // soft reset clears it like other state
   always_ff @(posedge CLK) begin
      if (SYS_RST || SOFT_RESET) begin
         WATCHDOG_FAULT <= 1'b0;
      end else if (wdog_exp) begin
         WATCHDOG_FAULT <= 1'b1;
      end else if (FAULT_READ) begin
         WATCHDOG_FAULT <= 1'b0;
      end
   end

   // safety expiry code held until read; set wins over read
   // only the safety expiry code is made here
   always_ff @(posedge CLK) begin
      if (SYS_RST || SOFT_RESET) begin
         CHARGE_FAULT_CODE <= 2'h0;
      end else if (safety_exp) begin
         CHARGE_FAULT_CODE <= ctbr_pkg::FAULT_SAFETY_TMR;
      end else if (FAULT_READ) begin
         CHARGE_FAULT_CODE <= 2'h0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // readback and decoded outputs
   // read data registered, held to next read
   // unmapped offsets return zero
   // reads have no side effect on registers
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         RDATA <= 8'h0;
      end else if (REQ.rd) begin
         case (REQ.addr)
            ctbr_pkg::OFS_TERM_TIMER: RDATA <= term_timer_r;
            ctbr_pkg::OFS_COMP_THERM: RDATA <= comp_therm_r;
            ctbr_pkg::OFS_OPT_BATSW:  RDATA <= opt_batsw_r;
            default:                  RDATA <= 8'h0; // unmapped reads zero
         endcase
      end
   end

   // register bits driven straight out
   assign OPT_START   = opt_batsw_r[ctbr_pkg::FOPT_BIT];
   assign PULSE_RAISE = opt_batsw_r[ctbr_pkg::RAISE_BIT];
   assign PULSE_LOWER = opt_batsw_r[ctbr_pkg::LOWER_BIT];
   assign SAFETY_TIMER_ENABLE = term_timer_r[ctbr_pkg::TMR_EN_BIT];

   // settings decoded into engineering units for the analogue loops
   // weights are whole lsb steps, so a product
   // suffices; 140 mohm and 224 mV fit 8 bits
   // thermal code maps to whole degrees C
   always_comb begin
      CFG.term_enable = term_timer_r[ctbr_pkg::TERM_EN_BIT];
      CFG.indicator_pin_disable =
         term_timer_r[ctbr_pkg::IND_DIS_BIT];
      CFG.timer_slowdown_enable = opt_batsw_r[ctbr_pkg::SLOW_BIT];
      CFG.system_reset_enable =
         opt_batsw_r[ctbr_pkg::SRST_EN_BIT];
      CFG.compensation_resistance = 8'(
         {5'h0, comp_therm_r[ctbr_pkg::CRES_LSB +: 3]} *
         ctbr_pkg::CRES_STEP_MOHM);
      CFG.compensation_clamp = 8'(
         {5'h0, comp_therm_r[ctbr_pkg::CCLAMP_LSB +: 3]} *
         ctbr_pkg::CCLAMP_STEP_MV);
      case (comp_therm_r[ctbr_pkg::THERMAL_REGULATION_THRESHOLD_LSB +: 2])
         2'h0:    CFG.thermal_regulation_threshold = ctbr_pkg::THERMAL_REGULATION_THRESHOLD_60;
         2'h1:    CFG.thermal_regulation_threshold = ctbr_pkg::THERMAL_REGULATION_THRESHOLD_80;
         2'h2:    CFG.thermal_regulation_threshold = ctbr_pkg::THERMAL_REGULATION_THRESHOLD_100;
         default: CFG.thermal_regulation_threshold = ctbr_pkg::THERMAL_REGULATION_THRESHOLD_120;
      endcase
   end
endmodule
`default_nettype wire

// File: verilog/ctbr_sec_timer.sv
// seconds counter with expiry pulse, tick input gates advancement
`timescale 1ns/1ps
`default_nettype none
module ctbr_sec_timer (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        clear,   // restart from zero
   input  wire logic        run,     // counting allowed
   input  wire logic        tick,    // one advance step
   input  wire logic [17:0] limit,   // expiry count, zero disables
   output logic             expired  // one-cycle pulse
);
   logic [17:0] count_r; // elapsed steps

   // count steps; restart from zero on expiry so one pulse per period
   always_ff @(posedge clk) begin
      if (rst || clear || !run || limit == 18'h0) begin
         count_r <= 18'h0;
         expired <= 1'b0;
      end else if (tick) begin
         if (count_r + 18'h1 >= limit) begin
            count_r <= 18'h0;
            expired <= 1'b1;
         end else begin
            count_r <= count_r + 18'h1;
            expired <= 1'b0;
         end
      end else begin
         expired <= 1'b0;
      end
   end
endmodule
`default_nettype wire
